/* inc/sci_consts.svh */
/*
 * Offsets, field positions, reset values and timing counts of the
 * serial interface baud chain and status flags.
 * Assumes a 32-bit classic Wishbone slave with byte offsets.
 */
`ifndef SCI_CONSTS_SVH
`define SCI_CONSTS_SVH

// Register byte offsets
`define SCI_OFS_CTRL    8'h00
`define SCI_OFS_STAT    8'h04
`define SCI_OFS_DATA    8'h08
`define SCI_OFS_MASK    8'h0c

// Control field positions
`define SCI_CTRL_RATE   0
`define SCI_CTRL_PRESC  4
`define SCI_CTRL_TE     8
`define SCI_CTRL_RE     9

// Status bit positions
`define SCI_ST_TRANSMIT_BUFFER_EMPTY_FLAG     0
`define SCI_ST_TC       1
`define SCI_ST_RECEIVE_DATA_FULL_FLAG     2
`define SCI_ST_IDLE     3
`define SCI_ST_OVR      4
`define SCI_ST_NF       5
`define SCI_ST_FE       6

// Flag groups and reset values
`define SCI_TX_GRP      7'h03
`define SCI_RX_GRP      7'h7c
`define SCI_IRQ_CAP     7'h1f
`define SCI_MASK_RST    7'h00
`define SCI_STAT_RST    7'h00

// Prescaler divisors
`define SCI_PRE_DIV0    6'd1
`define SCI_PRE_DIV1    6'd3
`define SCI_PRE_DIV2    6'd4
`define SCI_PRE_DIV3    6'd13
`define SCI_PRE_DIV4    6'd39

// Timing counts in receiver timing ticks or bit ticks
`define SCI_RT_LAST     4'hf
`define SCI_SMP_FIRST   4'h7
`define SCI_SMP_LAST    4'h9
`define SCI_RX_STOP     4'h9
`define SCI_TX_LOAD_CNT 4'h9
`define SCI_IDLE_LAST   8'd159

`endif

/* inc/sci_pkg.sv */
/*
 * Types of the serial interface baud chain and status flags.
 * Assumes sci_consts.svh for all numeric constants.
 */
`default_nettype none

package sci_pkg;
	typedef logic [2:0] sci_presc_t;
	typedef logic [2:0] sci_rate_t;
	typedef enum logic [0:0] {
		SCI_RX_IDLE,
		SCI_RX_BITS
	} sci_rx_e;
endpackage : sci_pkg

`default_nettype wire

/* logic/sci_baud_gen.sv */
/*
 * Baud chain: prescaler, binary rate selector, bit divider.
 * Assumes one core clock; outputs are one-cycle enable pulses.
 */
`include "sci_consts.svh"
`default_nettype none

module sci_baud_gen (
	input  wire logic                core_clk,
	input  wire logic                srst,
	input  wire sci_pkg::sci_presc_t prescSel,
	input  wire sci_pkg::sci_rate_t  rateSel,
	output logic                     rtTick,
	output logic                     bitTick
);
	import sci_pkg::*;

	function automatic logic [5:0] preDiv(input sci_presc_t s);
		case (s)
			3'h0: preDiv = `SCI_PRE_DIV0;
			3'h1: preDiv = `SCI_PRE_DIV1;
			3'h2: preDiv = `SCI_PRE_DIV2;
			3'h3: preDiv = `SCI_PRE_DIV3;
			default: preDiv = `SCI_PRE_DIV4;
		endcase
	endfunction : preDiv

	logic [5:0] preCnt_ff;
	logic [6:0] rateCnt_ff;
	logic [3:0] bitCnt_ff;
	logic       rt_ff;
	logic       bit_ff;

	wire [5:0] preLast = preDiv(prescSel) - 6'd1;
	wire       preTick = preCnt_ff >= preLast;
	wire [6:0] rateMask = 7'((8'h01 << rateSel) - 8'h01);
	wire       rtNow = preTick & ((rateCnt_ff & rateMask) == rateMask); // RL1
	wire       bitNow = rtNow & (bitCnt_ff == `SCI_RT_LAST); // RL2

	always_ff @(posedge core_clk) begin
		if (srst) begin
			preCnt_ff <= 6'h00;
			rateCnt_ff <= 7'h00;
			bitCnt_ff <= 4'h0;
			rt_ff <= 1'b0;
			bit_ff <= 1'b0;
		end else begin
			preCnt_ff <= preTick ? 6'h00 : preCnt_ff + 6'h01;
			if (preTick)
				rateCnt_ff <= rateCnt_ff + 7'h01;
			if (rtNow)
				bitCnt_ff <= bitCnt_ff + 4'h1;
			rt_ff <= rtNow;
			bit_ff <= bitNow;
		end
	end

	assign rtTick = rt_ff;
	assign bitTick = bit_ff;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_bit_from_rt: assert property (bitTick |-> rtTick) // RL2
		else $error("bit tick without timing tick");
	a_rt_from_pre: assert property (rtTick |-> $past(preTick)) // RL1
		else $error("timing tick without prescaler tick");
endmodule : sci_baud_gen

`default_nettype wire

/* logic/sci_core.sv */
/*
 * Serial interface core: Wishbone registers, baud chain, minimal
 * 8N1 transmitter and receiver, status flags and interrupt.
 * Assumes rxdPin is asynchronous; txdOut/txdOe drive a shared pin.
 */
// Overview of operation
// RL1: Prescaler feeds a power-of-two rate selector giving the 16x timing tick.
// RL2: Bit clock is the timing tick divided by sixteen.
// RL3: Rate select survives reset and is writable at any time.
// RL4: Flags set by hardware stay set until cleared by software.
// RL5: Enabling the transmitter sets buffer-empty and complete flags.
// RL6: Buffer-empty flag with its enable raises an interrupt.
// RL7: Transmission-complete flag with its enable raises an interrupt.
// RL8: Disable mid-character finishes it, drops queued data, shuts down.
// RL9: Only reset stops the transmitter at once; no character abort.
// RL10: Disable while idle releases the pin on a bit tick.
// RL11: Last character after disable still sets complete and empty.
// RL12: Five receiver flags; noise and framing never interrupt.
// RL13: Receive-full sets when a character lands in the data register.
// RL14: Overrun drops the new character, keeps data, sets overrun.
// RL15: Idle sets once after activity then a full high character.
// RL16: Software keeps low prescaler bits zero when the top bit is set.
// RL17: Status read then data access clears the flags seen set.
// RL18: All enabled flags but noise and framing combine into one level interrupt.
`include "sci_consts.svh"
`default_nettype none

module sci_core (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq,
	input  wire logic        rxdPin,
	output logic             txdOut,
	output logic             txdOe
);
	import sci_pkg::*;

	////////////////////////////////////////////////////////////////////
	// State
	logic        ack_ff;
	logic [31:0] datO_ff;
	logic        irq_ff;
	sci_rate_t   rateSel_ff = 3'h0;
	sci_presc_t  presc_ff;
	logic        teReq_ff;
	logic        re_ff;
	logic [6:0]  mask_ff;
	logic [6:0]  stat_ff;
	logic [6:0]  arm_ff;
	logic [7:0]  tdr_ff;
	logic        tdrFull_ff;
	logic [8:0]  txSh_ff;
	logic [3:0]  txCnt_ff;
	logic        txBusy_ff;
	logic        txOn_ff;
	logic        txd_ff;
	logic        rxM_ff;
	logic        rxS_ff;
	sci_rx_e     rxSt_ff;
	logic [3:0]  rxPh_ff;
	logic [3:0]  rxBit_ff;
	logic [2:0]  rxSmp_ff;
	logic [7:0]  rxSh_ff;
	logic        rxNoise_ff;
	logic [7:0]  rdr_ff;
	logic [7:0]  idleCnt_ff;
	logic        rxSeen_ff;
	logic        rtTick;
	logic        bitTick;

	////////////////////////////////////////////////////////////////////
	// Bus decode
	logic hitCtrl;
	logic hitStat;
	logic hitData;
	logic hitMask;
	wire  [7:0] ofs = {wb_adr_i[7:2], 2'b00};

	always_comb begin
		hitCtrl = 1'b0;
		hitStat = 1'b0;
		hitData = 1'b0;
		hitMask = 1'b0;
		if (ofs == `SCI_OFS_CTRL)
			hitCtrl = 1'b1;
		else if (ofs == `SCI_OFS_STAT)
			hitStat = 1'b1;
		else if (ofs == `SCI_OFS_DATA)
			hitData = 1'b1;
		else if (ofs == `SCI_OFS_MASK)
			hitMask = 1'b1;
	end

	wire req = wb_cyc_i & wb_stb_i;
	wire acc = req & ack_ff;
	wire wrAcc = acc & wb_we_i;
	wire rdAcc = acc & ~wb_we_i;
	wire wrCtrl = wrAcc & hitCtrl;
	wire wrStat = wrAcc & hitStat & wb_sel_i[0];
	wire wrMask = wrAcc & hitMask & wb_sel_i[0];
	wire dataWr = wrAcc & hitData & wb_sel_i[0];
	wire dataRd = rdAcc & hitData;
	wire statRd = rdAcc & hitStat;
	wire teRise = wrCtrl & wb_sel_i[1] & wb_dat_i[`SCI_CTRL_TE] & ~teReq_ff;

	////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge core_clk) begin
		if (wrCtrl & wb_sel_i[0])
			rateSel_ff <= wb_dat_i[`SCI_CTRL_RATE +: 3]; // RL3
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			presc_ff <= 3'h0;
			teReq_ff <= 1'b0;
			re_ff <= 1'b0;
			mask_ff <= `SCI_MASK_RST;
		end else begin
			if (wrCtrl & wb_sel_i[0])
				presc_ff <= wb_dat_i[`SCI_CTRL_PRESC +: 3];
			if (wrCtrl & wb_sel_i[1]) begin
				teReq_ff <= wb_dat_i[`SCI_CTRL_TE];
				re_ff <= wb_dat_i[`SCI_CTRL_RE];
			end
			if (wrMask)
				mask_ff <= wb_dat_i[6:0];
		end
	end

	sci_baud_gen u_baud (
		.core_clk (core_clk),
		.srst     (srst),
		.prescSel (presc_ff),
		.rateSel  (rateSel_ff),
		.rtTick   (rtTick),
		.bitTick  (bitTick)
	); // RL1 RL2

	////////////////////////////////////////////////////////////////////
	// Transmitter
	wire txSlot = bitTick & (txCnt_ff == 4'h0);
	wire txLoad = txSlot & tdrFull_ff & teReq_ff;
	wire txEnd = txSlot & txBusy_ff;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			tdr_ff <= 8'h00;
			tdrFull_ff <= 1'b0;
			txSh_ff <= 9'h1ff;
			txCnt_ff <= 4'h0;
			txBusy_ff <= 1'b0;
			txOn_ff <= 1'b0; // RL9
			txd_ff <= 1'b1;
		end else begin
			if (teRise)
				txOn_ff <= 1'b1;
			if (bitTick) begin
				if (txCnt_ff != 4'h0) begin
					txd_ff <= txSh_ff[0];
					txSh_ff <= {1'b1, txSh_ff[8:1]};
					txCnt_ff <= txCnt_ff - 4'h1; // RL9
				end else if (tdrFull_ff & teReq_ff) begin
					txd_ff <= 1'b0;
					txSh_ff <= {1'b1, tdr_ff};
					txCnt_ff <= `SCI_TX_LOAD_CNT;
					txBusy_ff <= 1'b1;
					tdrFull_ff <= 1'b0;
				end else begin
					txBusy_ff <= 1'b0;
					if (~teReq_ff) begin
						txOn_ff <= 1'b0; // RL8 RL10
						tdrFull_ff <= 1'b0; // RL8
						txd_ff <= 1'b1;
					end
				end
			end
			if (dataWr & teReq_ff) begin
				tdr_ff <= wb_dat_i[7:0];
				tdrFull_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receiver
	wire rxMaj = (rxSmp_ff[0] & rxSmp_ff[1]) | (rxSmp_ff[0] & rxSmp_ff[2])
		| (rxSmp_ff[1] & rxSmp_ff[2]);
	wire rxNoisy = (|rxSmp_ff) & ~(&rxSmp_ff);
	wire rxInWin = (rxPh_ff >= `SCI_SMP_FIRST) & (rxPh_ff <= `SCI_SMP_LAST);
	wire rxEval = rtTick & (rxSt_ff == SCI_RX_BITS) & (rxPh_ff == `SCI_RT_LAST);
	wire rxDone = rxEval & (rxBit_ff == `SCI_RX_STOP);
	wire rxFalse = rxEval & (rxBit_ff == 4'h0) & rxMaj;
	wire rxMid = (rxBit_ff != 4'h0) & (rxBit_ff != `SCI_RX_STOP);
	wire rxIdle = rxSt_ff == SCI_RX_IDLE;
	wire idleSet = rtTick & rxS_ff & rxIdle & rxSeen_ff
		& (idleCnt_ff == `SCI_IDLE_LAST);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rxM_ff <= 1'b1;
			rxS_ff <= 1'b1;
		end else begin
			rxM_ff <= rxdPin;
			rxS_ff <= rxM_ff;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rxSt_ff <= SCI_RX_IDLE;
			rxPh_ff <= 4'h0;
			rxBit_ff <= 4'h0;
			rxSmp_ff <= 3'h7;
			rxSh_ff <= 8'h00;
			rxNoise_ff <= 1'b0;
		end else if (rtTick) begin
			case (rxSt_ff)
				SCI_RX_IDLE: begin
					if (re_ff & ~rxS_ff) begin
						rxSt_ff <= SCI_RX_BITS;
						rxPh_ff <= 4'h1;
						rxBit_ff <= 4'h0;
						rxNoise_ff <= 1'b0;
					end
				end
				SCI_RX_BITS: begin
					rxPh_ff <= rxPh_ff + 4'h1;
					if (rxInWin)
						rxSmp_ff <= {rxSmp_ff[1:0], rxS_ff};
					if (rxEval) begin
						rxBit_ff <= rxBit_ff + 4'h1;
						rxNoise_ff <= rxNoise_ff | rxNoisy;
						if (rxMid)
							rxSh_ff <= {rxMaj, rxSh_ff[7:1]};
						if (rxFalse | rxDone)
							rxSt_ff <= SCI_RX_IDLE;
					end
				end
				default: rxSt_ff <= SCI_RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			rdr_ff <= 8'h00;
		else if (rxDone & ~stat_ff[`SCI_ST_RECEIVE_DATA_FULL_FLAG])
			rdr_ff <= rxSh_ff; // RL13 RL14
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			idleCnt_ff <= 8'h00;
			rxSeen_ff <= 1'b0;
		end else if (~rxS_ff) begin
			idleCnt_ff <= 8'h00;
			rxSeen_ff <= 1'b1;
		end else if (idleSet) begin
			idleCnt_ff <= 8'h00;
			rxSeen_ff <= 1'b0; // RL15
		end else if (rtTick & rxIdle & rxSeen_ff) begin
			idleCnt_ff <= idleCnt_ff + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status flags
	wire tdreSet = teRise | txLoad | (txEnd & ~teReq_ff); // RL5 RL6 RL11
	wire tcSet = teRise | (txEnd & ~txLoad); // RL5 RL7 RL11
	wire rxSet = rxDone & ~stat_ff[`SCI_ST_RECEIVE_DATA_FULL_FLAG]; // RL13
	wire ovrSet = rxDone & stat_ff[`SCI_ST_RECEIVE_DATA_FULL_FLAG]; // RL14
	wire nfSet = rxSet & (rxNoise_ff | rxNoisy); // RL12
	wire feSet = rxSet & ~rxMaj; // RL12
	wire [6:0] setV = {feSet, nfSet, ovrSet, idleSet, rxSet, tcSet, tdreSet};
	wire [6:0] seqClr = (dataWr ? arm_ff & `SCI_TX_GRP : 7'h00)
		| (dataRd ? arm_ff & `SCI_RX_GRP : 7'h00); // RL17
	wire [6:0] clrV = (wrStat ? wb_dat_i[6:0] : 7'h00) | seqClr;
	wire [6:0] nxt_stat = (stat_ff & ~clrV) | setV; // RL4

	always_ff @(posedge core_clk) begin
		if (srst) begin
			stat_ff <= `SCI_STAT_RST;
			arm_ff <= 7'h00;
			irq_ff <= 1'b0;
		end else begin
			stat_ff <= nxt_stat;
			arm_ff <= statRd ? stat_ff : arm_ff & ~seqClr; // RL17
			irq_ff <= |(stat_ff & mask_ff & `SCI_IRQ_CAP); // RL6 RL7 RL12 RL18
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read mux and acknowledge
	logic [31:0] rdVal;

	always_comb begin
		rdVal = 32'h0000_0000;
		if (hitCtrl)
			rdVal = {22'h0, re_ff, teReq_ff, 1'b0, presc_ff, 1'b0, rateSel_ff};
		else if (hitStat)
			rdVal = {25'h0, stat_ff};
		else if (hitData)
			rdVal = {24'h0, rdr_ff};
		else if (hitMask)
			rdVal = {25'h0, mask_ff};
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ack_ff <= 1'b0;
			datO_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= req & ~ack_ff;
			if (req & ~ack_ff)
				datO_ff <= rdVal;
		end
	end

	assign wb_dat_o = datO_ff;
	assign wb_ack_o = ack_ff;
	assign irq = irq_ff;
	assign txdOut = txd_ff;
	assign txdOe = txOn_ff;

	////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence s_lastChar;
		txEnd && !teReq_ff;
	endsequence

	sequence s_shutDone;
		!txOn_ff && !tdrFull_ff && stat_ff[0] && stat_ff[1];
	endsequence

	property p_shutdown;
		s_lastChar |=> s_shutDone;
	endproperty

	a_tx_shutdown: assert property (p_shutdown) // RL8 RL11
		else $error("disable did not finish cleanly");
	a_no_abort: assert property (txBusy_ff && !bitTick |=> txBusy_ff) // RL9
		else $error("character aborted");
	a_pin_release: assert property (
		$fell(txOn_ff) && !$past(srst) |-> $past(bitTick)) // RL10
		else $error("pin released off a bit tick");
	a_enable_flags: assert property (teRise |=> stat_ff[0] && stat_ff[1]) // RL5
		else $error("enable did not set transmit flags");
	a_transmit_buffer_empty_flag_irq: assert property (stat_ff[0] && mask_ff[0] |=> irq_ff) // RL6
		else $error("empty interrupt missing");
	a_tc_irq: assert property (stat_ff[1] && mask_ff[1] |=> irq_ff) // RL7
		else $error("complete interrupt missing");
	a_irq_quiet: assert property (
		(stat_ff & mask_ff & `SCI_IRQ_CAP) == 7'h00 |=> !irq_ff) // RL12 RL18
		else $error("interrupt without enabled flag");
	a_receive_data_full_flag_load: assert property (
		rxSet |=> stat_ff[2] && rdr_ff == $past(rxSh_ff)) // RL13
		else $error("receive data not loaded");
	a_overrun_keep: assert property (
		ovrSet |=> stat_ff[4] && $stable(rdr_ff)) // RL14
		else $error("overrun handled wrongly");
	a_idle_once: assert property (
		idleSet |-> rxSeen_ff ##1 !rxSeen_ff && stat_ff[3]) // RL15
		else $error("idle flag misfired");
	a_flag_hold: assert property (
		stat_ff[2] && !clrV[2] |=> stat_ff[2]) // RL4
		else $error("flag dropped on its own");
	a_seq_clear: assert property (
		dataWr && arm_ff[0] && !tdreSet |=> !stat_ff[0]) // RL17
		else $error("clearing sequence ignored");
	a_rate_keep: assert property (disable iff (1'b0)
		srst && !wrCtrl |=> $stable(rateSel_ff)) // RL3
		else $error("rate select changed by reset");
endmodule : sci_core

`default_nettype wire

/* tb/sci_remote_node.sv */
/*
 * Remote serial node: sends and decodes 8N1 frames.
 * Assumes bitClks core clocks per bit and a pulled-up line.
 */
`default_nettype none

module sci_remote_node (
	input  wire logic        core_clk,
	input  wire logic        txPin,
	input  wire logic [15:0] bitClks,
	output logic             rxdLine
);
	timeunit 1ns;
	timeprecision 1ns;
	int         rxCount = 0;
	int         lowRun  = 0;
	logic [7:0] rxLast;

	initial rxdLine = 1'b1;

	////////////////////////////////////////////////////////////////////
	// Frame sender, start low, LSB first, caller picks stop level
	task automatic send_frame(input logic [7:0] d, input logic stopLvl);
		logic [9:0] f;
		f = {stopLvl, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxdLine <= f[i];
			repeat (bitClks) @(posedge core_clk);
		end
		rxdLine <= 1'b1;
	endtask : send_frame

	////////////////////////////////////////////////////////////////////
	// Length of each start bit, sampled mid-cycle; data bit 0 is 1
	always @(negedge txPin) begin : low_meter
		int n;
		n = 0;
		@(negedge core_clk);
		while (txPin === 1'b0 && n < 9000) begin
			n++;
			@(negedge core_clk);
		end
		lowRun = n;
		repeat (bitClks * 8) @(negedge core_clk);
	end

	// Frame decoder, samples at bit centres
	always @(negedge txPin) begin : frame_rx
		logic [7:0] d;
		repeat (bitClks / 2) @(negedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bitClks) @(negedge core_clk);
			d[i] = txPin;
		end
		repeat (bitClks) @(negedge core_clk);
		if (txPin === 1'b1) begin
			rxCount++;
			rxLast = d;
		end
	end
endmodule : sci_remote_node

`default_nettype wire

/* tb/test_sci_baud_and_status_flags.sv */
/*
 * Self-checking bench of the serial core: baud chain, flags, irq.
 * Assumes sci_remote_node on the line and a pulled-up tx pin.
 */
`include "sci_consts.svh"
`default_nettype none

module test_sci_baud_and_status_flags;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk;
	logic        srst;
	logic        wbCyc;
	logic        wbStb;
	logic        wbWe;
	logic [7:0]  wbAdr;
	logic [31:0] wbDatI;
	logic [3:0]  wbSel;
	logic [31:0] wbDatO;
	logic        wbAck;
	logic        irq;
	logic        rxdPin;
	logic        txdOut;
	logic        txdOe;
	logic        txPin;
	logic [15:0] bitClks;
	logic [31:0] st;
	logic [7:0]  b;
	logic [7:0]  b0;
	logic [2:0]  pTab [8] = '{0, 0, 1, 2, 3, 4, 4, 0};
	logic [2:0]  rTab [8] = '{0, 2, 0, 1, 0, 0, 1, 7};
	int          bad_count = 0;
	int          compares  = 0;
	int          cycles    = 0;

	sci_core i_dut (
		.core_clk (core_clk),
		.srst     (srst),
		.wb_cyc_i (wbCyc),
		.wb_stb_i (wbStb),
		.wb_we_i  (wbWe),
		.wb_adr_i (wbAdr),
		.wb_dat_i (wbDatI),
		.wb_sel_i (wbSel),
		.wb_dat_o (wbDatO),
		.wb_ack_o (wbAck),
		.irq      (irq),
		.rxdPin   (rxdPin),
		.txdOut   (txdOut),
		.txdOe    (txdOe)
	);

	sci_remote_node i_node (
		.core_clk (core_clk),
		.txPin    (txPin),
		.bitClks  (bitClks),
		.rxdLine  (rxdPin)
	);

	assign txPin = (txdOe === 1'b1) ? txdOut : 1'b1;

	always #5 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 95000) begin
			bad_count++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////
	function automatic int bit_clks(input logic [2:0] p, input logic [2:0] r);
		int d;
		case (p)
			3'h0: d = 1;
			3'h1: d = 3;
			3'h2: d = 4;
			3'h3: d = 13;
			default: d = 39;
		endcase
		return 16 * d * (1 << r);
	endfunction : bit_clks

	function automatic logic [31:0] ctrl(input logic [2:0] p,
			input logic [2:0] r, input logic te, input logic re);
		return {22'h0, re, te, 1'b0, p, 1'b0, r};
	endfunction : ctrl

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string msg);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic wb(input logic we, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] rdat);
		int n;
		@(posedge core_clk);
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= we;
		wbAdr  <= a;
		wbDatI <= wd;
		wbSel  <= 4'hf;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 64);
		rdat = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe  <= 1'b0;
		if (n >= 64) begin
			bad_count++;
			$display("unexpected at %0t: no ack", $time);
		end
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		wb(1'b1, a, d, x);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		wb(1'b0, a, 32'h0, d);
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(negedge core_clk);
	endtask : settle

	task automatic wait_rx(input int cnt);
		int n;
		n = 0;
		while (i_node.rxCount < cnt && n < 40000) begin
			@(posedge core_clk);
			n++;
		end
		chk(32'(i_node.rxCount), 32'(cnt), "frame count");
	endtask : wait_rx

	task complete_run;
		$display("comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		srst     = 1'b1;
		wbCyc    = 1'b0;
		wbStb    = 1'b0;
		wbWe     = 1'b0;
		wbAdr    = 8'h00;
		wbDatI   = 32'h0;
		wbSel    = 4'hf;
		bitClks  = 16'h10;
		void'($urandom(32'hc394cd69));
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		rd(`SCI_OFS_STAT, st);
		chk(st, 32'h0, "status at reset");
		rd(`SCI_OFS_MASK, st);
		chk(st, 32'h0, "mask at reset");
		rd(8'h10, st);
		chk(st, 32'h0, "unmapped read");
		chk(32'(txdOe), 32'h0, "pin at reset");
		$display("test reset done");
		// Enable, interrupt gating, idle disable
		wr(`SCI_OFS_CTRL, ctrl(3'h0, 3'h0, 1'b1, 1'b1));
		rd(`SCI_OFS_STAT, st);
		chk(st & 32'h3, 32'h3, "flags on enable");
		wr(`SCI_OFS_STAT, 32'h2);
		wr(`SCI_OFS_MASK, 32'h2);
		settle(3);
		chk(32'(irq), 32'h0, "complete irq");
		wr(`SCI_OFS_MASK, 32'h1);
		settle(3);
		chk(32'(irq), 32'h1, "empty irq");
		wr(`SCI_OFS_MASK, 32'h0);
		settle(3);
		chk(32'(irq), 32'h0, "masked irq");
		wr(`SCI_OFS_CTRL, ctrl(3'h0, 3'h0, 1'b0, 1'b1));
		settle(17);
		chk(32'(txdOe), 32'h0, "idle release");
		$display("test enable done");
		// Baud chain over prescaler and rate codes
		for (int k = 0; k < 8; k++) begin
			wr(`SCI_OFS_CTRL, ctrl(pTab[k], rTab[k], 1'b1, 1'b1));
			bitClks = 16'(bit_clks(pTab[k], rTab[k]));
			b = 8'($urandom()) | 8'h01;
			wr(`SCI_OFS_DATA, {24'h0, b});
			wait_rx(k + 1);
			chk(32'(i_node.lowRun), 32'(bitClks), "bit period");
			chk(32'(i_node.rxLast), 32'(b), "tx byte");
			repeat (bitClks) @(posedge core_clk);
		end
		$display("test baud done");
		// Disable while a second character waits
		bitClks = 16'h10;
		wr(`SCI_OFS_CTRL, ctrl(3'h0, 3'h0, 1'b1, 1'b1));
		b0 = 8'($urandom());
		wr(`SCI_OFS_DATA, {24'h0, b0});
		repeat (20) @(posedge core_clk);
		rd(`SCI_OFS_STAT, st);
		wr(`SCI_OFS_DATA, 32'h5a);
		rd(`SCI_OFS_STAT, st);
		chk(st & 32'h3, 32'h0, "tx clear sequence");
		wr(`SCI_OFS_CTRL, ctrl(3'h0, 3'h0, 1'b0, 1'b1));
		wait_rx(9);
		repeat (300) @(posedge core_clk);
		chk(32'(i_node.rxCount), 32'd9, "queue dropped");
		chk(32'(i_node.rxLast), 32'(b0), "char finished");
		rd(`SCI_OFS_STAT, st);
		chk(st & 32'h3, 32'h3, "flags after last");
		chk(32'(txdOe), 32'h0, "shut down");
		wr(`SCI_OFS_MASK, 32'h2);
		settle(3);
		chk(32'(irq), 32'h1, "complete irq set");
		$display("test disable done");
		// Receive, overrun, idle, framing
		wr(`SCI_OFS_CTRL, ctrl(3'h0, 3'h0, 1'b1, 1'b1));
		wr(`SCI_OFS_STAT, 32'h7f);
		b0 = 8'($urandom());
		b = 8'($urandom());
		i_node.send_frame(b0, 1'b1);
		repeat (40) @(posedge core_clk);
		rd(`SCI_OFS_STAT, st);
		chk(st & 32'h7c, 32'h04, "rx full, no idle");
		wr(`SCI_OFS_MASK, 32'h04);
		settle(3);
		chk(32'(irq), 32'h1, "rx irq");
		@(posedge core_clk);
		i_node.send_frame(b, 1'b1);
		repeat (40) @(posedge core_clk);
		rd(`SCI_OFS_STAT, st);
		chk(st & 32'h14, 32'h14, "overrun");
		rd(`SCI_OFS_DATA, st);
		chk(st & 32'hff, 32'(b0), "data kept");
		rd(`SCI_OFS_STAT, st);
		chk(st & 32'h14, 32'h0, "rx clear sequence");
		repeat (250) @(posedge core_clk);
		rd(`SCI_OFS_STAT, st);
		chk(st & 32'h08, 32'h08, "idle set");
		wr(`SCI_OFS_STAT, 32'h08);
		repeat (300) @(posedge core_clk);
		rd(`SCI_OFS_STAT, st);
		chk(st & 32'h08, 32'h0, "idle once");
		@(posedge core_clk);
		i_node.send_frame(b, 1'b0);
		repeat (40) @(posedge core_clk);
		rd(`SCI_OFS_STAT, st);
		chk(st & 32'h60, 32'h40, "framing flag");
		wr(`SCI_OFS_MASK, 32'h60);
		settle(3);
		chk(32'(irq), 32'h0, "framing no irq");
		$display("test receive done");
		// Reset in mid-character keeps the rate field
		bitClks = 16'h40;
		wr(`SCI_OFS_CTRL, ctrl(3'h0, 3'h2, 1'b1, 1'b1));
		wr(`SCI_OFS_DATA, 32'h3c);
		repeat (100) @(posedge core_clk);
		srst <= 1'b1;
		@(posedge core_clk);
		srst <= 1'b0;
		settle(1);
		chk({30'h0, txdOe, txdOut}, 32'h1, "reset stops tx");
		rd(`SCI_OFS_CTRL, st);
		chk(st & 32'h7, 32'h2, "rate kept");
		$display("test reset rate done");
		complete_run();
	end
endmodule : test_sci_baud_and_status_flags

`default_nettype wire
